// ---- fsp_pkg.sv ----
// holds constants shared by the flash status/protect/pause block
// assumes a 20 mhz system clock sampling the serial pins
// What this block does
// - pause falling edge with clock low enters pause
// - pause rising edge with clock low leaves pause
// - pause falling while clock high waits clock low
// - pause rising while clock high waits clock low
// - paused: output floats, clock and input ignored
// - select high while paused ends the sequence, but a command already fully shifted in still executes
// - status write refused when guard low and locked
// - bit 0 busy during program or erase
// - write latch clear refuses program and erase
// - write latch cleared on listed completions
// - bit 6 shows auto-increment mode
// - three guard bits select protected upper region
// - whole-array erase only with all guards zero
// - guard low and locked freezes guard bits
// - power-up guards 111, lock and bit5 zero
// - status write opcode 01, applied on deselect
// - opcode 05 streams status seven times, then zeros until deselect
package fsp_pkg;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_AAI_PROGRAM = 8'had;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  // status bit positions
  localparam int BIT_BUSY = 0;
  localparam int BIT_WEL = 1;
  localparam int BIT_RG0 = 2;
  localparam int BIT_RG3 = 5;
  localparam int BIT_AAI = 6;
  localparam int BIT_LOCK = 7;
  localparam logic [7:0] STATUS_RESET = 8'h1c;
  localparam logic [7:0] WRITABLE_MASK = 8'hbc;
  localparam logic [23:0] ARRAY_TOP = 24'h3fffff;
  // command lengths in serial clocks: opcode plus address, opcode alone, opcode plus data
  localparam logic [5:0] ADDR_CMD_BITS = 6'h20;
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] STATUS_WRITE_CMD_BITS = 6'h10;
  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_ACTIVE,
    FSP_PAUSED
  } fsp_state_type;
endpackage

// ---- fsp_sync.sv ----
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clock_in
`timescale 1ns/1ps
module fsp_sync
  import fsp_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic level_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  // level follows only once stages two and three agree
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      lvl_ff <= INIT;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end
  assign level_out = lvl_ff;
endmodule

// ---- fsp_top.sv ----
// serial flash status register, write guard and pause logic
// assumes host drives pins; array engine reports busy and events
`timescale 1ns/1ps
module fsp_top
  import fsp_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic sclk_in,
  input wire logic select_n_in,
  input wire logic sdata_in,
  input wire logic pause_n_in,
  input wire logic write_guard_n_in,
  input wire logic array_busy_in,
  input wire logic aai_active_in,
  input wire logic aai_done_in,
  output logic sdata_out,
  output logic sdata_oe_out,
  output logic [7:0] status_out,
  output logic [23:0] protect_base_out,
  output logic protect_none_out,
  output logic program_start_out,
  output logic erase_start_out,
  output logic chip_erase_start_out,
  output logic [7:0] cmd_out,
  output logic [23:0] addr_out
);
  logic sck_s;
  logic sel_n_s;
  logic si_s;
  logic pause_n_s;
  logic guard_n_s;
  fsp_sync #(.INIT(1'b0)) u_sck (.clock_in(clock_in), .reset_in(reset_in),
    .pin_in(sclk_in), .level_out(sck_s));
  fsp_sync #(.INIT(1'b1)) u_sel (.clock_in(clock_in), .reset_in(reset_in),
    .pin_in(select_n_in), .level_out(sel_n_s));
  fsp_sync #(.INIT(1'b0)) u_si (.clock_in(clock_in), .reset_in(reset_in),
    .pin_in(sdata_in), .level_out(si_s));
  fsp_sync #(.INIT(1'b1)) u_hold (.clock_in(clock_in), .reset_in(reset_in),
    .pin_in(pause_n_in), .level_out(pause_n_s));
  fsp_sync #(.INIT(1'b1)) u_wp (.clock_in(clock_in), .reset_in(reset_in),
    .pin_in(write_guard_n_in), .level_out(guard_n_s));

  logic sck_d_ff;
  logic sel_d_ff;
  fsp_state_type state_ff;
  fsp_state_type nxt_state;
  logic [5:0] count_ff;
  logic [7:0] op_ff;
  logic [23:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] tx_ff;
  logic out_ff;
  logic oe_ff;
  logic wel_ff;
  logic [5:0] guard_ff;
  logic prog_ff;
  logic erase_ff;
  logic chip_ff;

  // edge detection on the filtered serial clock and select
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sck_d_ff <= 1'b0;
      sel_d_ff <= 1'b1;
    end else begin
      sck_d_ff <= sck_s;
      sel_d_ff <= sel_n_s;
    end
  end

  wire sck_rise = sck_s & ~sck_d_ff;
  wire sck_fall = ~sck_s & sck_d_ff;
  wire deselect = sel_n_s & ~sel_d_ff;
  wire paused = (state_ff == FSP_PAUSED);
  // pause level is honoured only in the clock low phase, so an edge seen
  // with clock high simply waits for low
  wire enter_pause = ~pause_n_s & ~sck_s & ~sel_n_s;
  wire leave_pause = pause_n_s & ~sck_s;
  wire shift_ok = (state_ff == FSP_ACTIVE);
  wire bit_in = shift_ok & sck_rise;
  wire bit_out = shift_ok & sck_fall;

  // status byte as read by the host
  wire [7:0] status_now = {guard_ff[BIT_LOCK-2], aai_active_in,
    guard_ff[BIT_RG3-2:0], wel_ff, array_busy_in};
  wire lock_on = ~guard_n_s & guard_ff[BIT_LOCK-2];
  wire [7:0] wr_byte = data_ff;
  wire status_write_cmd_ok = ~lock_on;
  wire cmd_done = deselect & (state_ff != FSP_IDLE);
  wire is_status_write_cmd = (op_ff == OP_STATUS_WRITE) && (count_ff == STATUS_WRITE_CMD_BITS);
  wire is_write_enable_cmd = (op_ff == OP_WRITE_ENABLE) && (count_ff == OPCODE_BITS);
  wire is_write_disable_cmd = (op_ff == OP_WRITE_DISABLE) && (count_ff == OPCODE_BITS);
  wire is_chip = ((op_ff == OP_CHIP_ERASE_A) || (op_ff == OP_CHIP_ERASE_B))
    && (count_ff == OPCODE_BITS);
  wire is_erase = ((op_ff == OP_SECTOR_ERASE) || (op_ff == OP_BLOCK32_ERASE)
    || (op_ff == OP_BLOCK64_ERASE)) && (count_ff == ADDR_CMD_BITS);
  wire is_prog = (op_ff == OP_BYTE_PROGRAM)
    && (count_ff == ADDR_CMD_BITS + OPCODE_BITS);

  // protected region starts at top minus size chosen by low three guards
  function automatic logic [23:0] region_base(input logic [2:0] g);
    case (g)
      3'h1: region_base = 24'h3f0000;
      3'h2: region_base = 24'h3e0000;
      3'h3: region_base = 24'h3c0000;
      3'h4: region_base = 24'h380000;
      3'h5: region_base = 24'h300000;
      3'h6: region_base = 24'h200000;
      default: region_base = 24'h000000;
    endcase
  endfunction
  wire [23:0] prot_base = region_base(guard_ff[2:0]);
  wire prot_none = (guard_ff[2:0] == 3'h0);
  wire addr_protected = ~prot_none & (addr_ff >= prot_base);
  wire busy_block = array_busy_in; // host must only poll here

  // pause state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FSP_IDLE: if (~sel_n_s && sel_d_ff) nxt_state = FSP_ACTIVE;
      FSP_ACTIVE: begin
        if (sel_n_s) nxt_state = FSP_IDLE;
        else if (enter_pause) nxt_state = FSP_PAUSED;
      end
      FSP_PAUSED: begin
        if (sel_n_s) nxt_state = FSP_IDLE; // abandon on deselect
        else if (leave_pause) nxt_state = FSP_ACTIVE;
      end
      default: nxt_state = FSP_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) state_ff <= FSP_IDLE;
    else state_ff <= nxt_state;
  end

  // shift register and bit counter, frozen while paused
  always_ff @(posedge clock_in) begin
    if (reset_in || (state_ff == FSP_IDLE)) begin
      count_ff <= 6'h00;
      op_ff <= 8'h00;
      addr_ff <= 24'h000000;
      data_ff <= 8'h00;
    end else if (bit_in) begin
      if (count_ff < OPCODE_BITS) op_ff <= {op_ff[6:0], si_s};
      else if (count_ff < ADDR_CMD_BITS) addr_ff <= {addr_ff[22:0], si_s};
      data_ff <= {data_ff[6:0], si_s}; // msb first
      if (count_ff != 6'h3f) count_ff <= count_ff + 6'h01;
    end
  end

  // status read streams the byte seven times, reloaded each byte until the bit counter saturates
  always_ff @(posedge clock_in) begin
    if (reset_in || sel_n_s) begin
      tx_ff <= 8'h00;
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (bit_out && op_ff == OP_STATUS_READ
        && count_ff >= OPCODE_BITS) begin
      if (count_ff[2:0] == 3'h0) begin
        out_ff <= status_now[7];
        tx_ff <= {status_now[6:0], 1'b0};
      end else begin
        out_ff <= tx_ff[7];
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
      oe_ff <= 1'b1;
    end
  end

  // write latch, guard bits and launch pulses, acted on at deselect; aai done also clears the latch in any cycle
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wel_ff <= 1'b0;
      guard_ff <= STATUS_RESET[7:2] & 6'h07;
      prog_ff <= 1'b0;
      erase_ff <= 1'b0;
      chip_ff <= 1'b0;
    end else begin
      prog_ff <= 1'b0;
      erase_ff <= 1'b0;
      chip_ff <= 1'b0;
      if (cmd_done && !busy_block) begin
        if (is_write_enable_cmd) wel_ff <= 1'b1;
        if (is_write_disable_cmd) wel_ff <= 1'b0;
        if (is_status_write_cmd) begin
          // applied only after select rises
          if (status_write_cmd_ok && wel_ff) begin
            guard_ff <= {wr_byte[BIT_LOCK], 1'b0, wr_byte[BIT_RG3:BIT_RG0]}
              & WRITABLE_MASK[7:2] | 6'h00;
          end
          wel_ff <= 1'b0;
        end
        if (is_prog) begin
          prog_ff <= wel_ff & ~addr_protected;
          wel_ff <= 1'b0;
        end
        if (is_erase) begin
          erase_ff <= wel_ff & ~addr_protected;
          wel_ff <= 1'b0;
        end
        if (is_chip) begin
          chip_ff <= wel_ff & (guard_ff[3:0] == 4'h0);
          wel_ff <= 1'b0;
        end
      end
      if (aai_done_in) wel_ff <= 1'b0; // aai end or top reached
    end
  end

  assign sdata_out = out_ff;
  assign sdata_oe_out = oe_ff & ~paused; // floats while paused
  assign status_out = status_now;
  assign protect_base_out = prot_base;
  assign protect_none_out = prot_none;
  assign program_start_out = prog_ff;
  assign erase_start_out = erase_ff;
  assign chip_erase_start_out = chip_ff;
  assign cmd_out = op_ff;
  assign addr_out = addr_ff;
endmodule

// ---- fsp_assertions.sv ----
// port assertions for the status, guard and pause block
// assumes binding into fsp_top; one clock domain
`timescale 1ns/1ps
module fsp_checker (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic sclk_in,
  input wire logic select_n_in,
  input wire logic pause_n_in,
  input wire logic write_guard_n_in,
  input wire logic array_busy_in,
  input wire logic aai_active_in,
  input wire logic aai_done_in,
  input wire logic sdata_oe_out,
  input wire logic [7:0] status_out,
  input wire logic [23:0] protect_base_out,
  input wire logic protect_none_out,
  input wire logic program_start_out,
  input wire logic erase_start_out,
  input wire logic chip_erase_start_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  // engine levels show up in status within a cycle
  AST_BUSY: assert property (
    $rose(array_busy_in) |-> ##[0:1] status_out[0]) else $error("busy lost");
  AST_AAI: assert property (
    $rose(aai_active_in) |-> ##[0:1] status_out[6]) else $error("aai lost");
  AST_WEL_DONE: assert property (
    aai_done_in |-> ##[0:2] !status_out[1]) else $error("latch kept");
  // any start needs the latch set the cycle before
  AST_GATE: assert property (
    (program_start_out || erase_start_out || chip_erase_start_out)
    |-> $past(status_out[1])) else $error("start without latch");
  AST_CHIP: assert property (
    chip_erase_start_out |-> $past(status_out[5:2]) == 4'h0)
    else $error("chip erase while guarded");
  // guard pin held low long enough to be past its synchroniser
  AST_LOCK: assert property (
    (!write_guard_n_in [*8] ##0 status_out[7])
    |=> $stable({status_out[7], status_out[5:2]})) else $error("lock broken");
  AST_NONE: assert property (
    $stable(status_out[4:2]) |-> protect_none_out == (status_out[4:2] == 3'h0))
    else $error("none flag wrong");
  AST_ALL: assert property (
    $stable(status_out[4:2]) && status_out[4:2] == 3'h7
    |-> protect_base_out == 24'h000000) else $error("base wrong");
  AST_PAUSE: assert property (
    $fell(pause_n_in) && !sclk_in && !select_n_in |-> ##[1:12] !sdata_oe_out)
    else $error("output not floated");
endmodule
bind fsp_top fsp_checker i_chk (.clock_in(clock_in), .reset_in(reset_in),
  .sclk_in(sclk_in), .select_n_in(select_n_in), .pause_n_in(pause_n_in),
  .write_guard_n_in(write_guard_n_in), .array_busy_in(array_busy_in),
  .aai_active_in(aai_active_in), .aai_done_in(aai_done_in),
  .sdata_oe_out(sdata_oe_out), .status_out(status_out),
  .protect_base_out(protect_base_out), .protect_none_out(protect_none_out),
  .program_start_out(program_start_out), .erase_start_out(erase_start_out),
  .chip_erase_start_out(chip_erase_start_out));

// ---- fsp_host_model.sv ----
// serial host model driving clock, select, data and pause pins
// assumes a 50 ns clock; serial clock 400 ns, idle low between frames
`timescale 1ns/1ps
module fsp_host_model (
  input wire logic clock_in,
  input wire logic sdata_in,
  output logic sclk_out,
  output logic select_n_out,
  output logic sdata_out,
  output logic pause_n_out
);
  logic [7:0] rx = 8'h00;
  initial begin
    sclk_out = 1'b0;
    select_n_out = 1'b1;
    sdata_out = 1'b0;
    pause_n_out = 1'b1;
  end
  // sample late in the high phase, after the device output settles
  task automatic bit_cyc(input logic b);
    sdata_out <= b;
    repeat (4) @(posedge clock_in);
    sclk_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    rx = {rx[6:0], sdata_in};
    sclk_out <= 1'b0;
  endtask
  // clocks and data while paused are noise the device must ignore
  task automatic pause_it();
    logic [7:0] keep;
    // noise clocks must not shift the received byte
    keep = rx;
    @(posedge clock_in);
    pause_n_out <= 1'b0;
    sdata_out <= 1'b1;
    repeat (2) bit_cyc(1'b1);
    repeat (8) @(posedge clock_in);
    pause_n_out <= 1'b1;
    repeat (8) @(posedge clock_in);
    rx = keep;
  endtask
  // one framed command, msb first, optional data byte
  task automatic frame(input logic [7:0] op, input logic [7:0] d,
    input logic has_d, input logic hold);
    logic [15:0] v;
    v = {op, d};
    select_n_out <= 1'b0;
    repeat (4) @(posedge clock_in);
    for (int i = 15; i >= (has_d ? 0 : 8); i--) begin
      bit_cyc(v[i]);
      if (hold && i == 4)
        pause_it();
    end
    repeat (4) @(posedge clock_in);
    select_n_out <= 1'b1;
    sdata_out <= ~sdata_out;
    repeat (12) @(posedge clock_in);
  endtask
endmodule

// ---- tb_flash_status_protect_hold.sv ----
// bench for the status, guard and pause block
// assumes the host model owns the serial pins
`timescale 1ns/1ps
module tb_flash_status_protect_hold;
  import fsp_pkg::*;
  logic clk, rst, guard_n, busy, auto_increment_flag, aai_done;
  logic sclk, sel_n, si, pause_n, so, so_oe, none, chip;
  logic [7:0] st;
  logic [23:0] base;
  wire so_w;
  int fail_count = 0;
  int n_checks = 0;
  int chips = 0;
  // a floated output wiggles so a stale bit cannot pass
  assign so_w = so_oe ? so : ~clk;
  fsp_host_model i_host (.clock_in(clk), .sdata_in(so_w), .sclk_out(sclk),
    .select_n_out(sel_n), .sdata_out(si), .pause_n_out(pause_n));
  fsp_top i_dut (.clock_in(clk), .reset_in(rst), .sclk_in(sclk),
    .select_n_in(sel_n), .sdata_in(si), .pause_n_in(pause_n),
    .write_guard_n_in(guard_n), .array_busy_in(busy), .aai_active_in(auto_increment_flag),
    .aai_done_in(aai_done), .sdata_out(so), .sdata_oe_out(so_oe),
    .status_out(st), .protect_base_out(base), .protect_none_out(none),
    .program_start_out(), .erase_start_out(), .chip_erase_start_out(chip),
    .cmd_out(), .addr_out());
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) chips <= chips + int'(chip);
  // compare mid-cycle, then realign to the rising edge
  task automatic chk(input string nm, input logic [23:0] exp, got);
    @(negedge clk);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
    @(posedge clk);
  endtask
  task automatic wrs(input logic [7:0] d);
    i_host.frame(OP_WRITE_ENABLE, 8'h00, 1'b0, 1'b0);
    i_host.frame(OP_STATUS_WRITE, d, 1'b1, 1'b0);
  endtask
  task automatic cmd(input logic [7:0] op);
    i_host.frame(OP_WRITE_ENABLE, 8'h00, 1'b0, 1'b0);
    i_host.frame(op, 8'h00, 1'b0, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    // engine idle and guard pin high, so the first frames are not refused
    {rst, guard_n, busy, auto_increment_flag, aai_done} = 5'h08;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk("status", 24'(STATUS_RESET), 24'(st));
    chk("base", 24'h000000, base);
    // every guard code, read back; one read is paused mid-byte
    for (int k = 7; k >= 0; k--) begin
      wrs(8'(k << 2));
      chk("status", 24'(k << 2), 24'(st));
      chk("none", 24'(k == 0), 24'(none));
      if (k != 0)
        chk("base", 24'h400000 - (24'h400000 >> (7 - k)), base);
      i_host.frame(OP_STATUS_READ, 8'h00, 1'b1, k == 3);
      chk("read", 24'(k << 2), 24'(i_host.rx));
    end
    $display("test guard codes done");
    i_host.frame(OP_CHIP_ERASE_A, 8'h00, 1'b0, 1'b0);
    cmd(OP_CHIP_ERASE_B);
    chk("chip", 24'h000001, 24'(chips));
    chk("wel", 24'h000000, 24'(st[1]));
    wrs(8'h04);
    cmd(OP_CHIP_ERASE_A);
    chk("chip", 24'h000001, 24'(chips));
    $display("test erase gating done");
    guard_n <= 1'b0;
    wrs(8'h88);
    chk("lock", 24'h000088, 24'(st & WRITABLE_MASK));
    wrs(8'h00);
    chk("lock", 24'h000088, 24'(st & WRITABLE_MASK));
    guard_n <= 1'b1;
    wrs(8'h00);
    chk("lock", 24'h000000, 24'(st & WRITABLE_MASK));
    $display("test lock done");
    // no frame is sent while the engine is busy
    busy <= 1'b1;
    auto_increment_flag <= 1'b1;
    repeat (3) @(posedge clk);
    chk("flags", 24'h000041, 24'(st & 8'h41));
    busy <= 1'b0;
    repeat (3) @(posedge clk);
    i_host.frame(OP_WRITE_ENABLE, 8'h00, 1'b0, 1'b0);
    chk("wel", 24'h000001, 24'(st[1]));
    aai_done <= 1'b1;
    @(posedge clk);
    aai_done <= 1'b0;
    auto_increment_flag <= 1'b0;
    repeat (3) @(posedge clk);
    chk("wel", 24'h000000, 24'(st[1]));
    $display("test engine flags done");
    tally_and_finish();
  end
endmodule
